// ---- rtl/sws_defines.svh ----
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH
// Notes on behaviour
// - top address byte is an 8-bit crc over the lower 56 address bits
// - address crc is never checked here; sequences always continue
// - line is only pulled low or released, never driven high
// - line low longer than 120 us is a reset; transaction abandoned
// - order: reset, presence, address command, function command, data
// - read address command sends 64 bits; opcode 33h or 39h by select
// - match 55h plus 64 bits selects only on equal address
// - skip CCh selects without an address
// - search F0h sends bit then complement, then master writes bit
// - swap AAh: fall cuts power; rise restores if addressed, else sleep
// - swap command only recognised while swap enable is set
// - read 69h sends lsb first, address increments after each msb
// - reading past FFh returns ones until the next reset
// - write 6Ch takes lsb first, auto-increment, drops data past FFh
// - read-only, reserved, locked writes and partial bytes are dropped
// - eeprom-range writes land in shadow ram only
// - copy 48h moves shadow block to eeprom unless block locked
// - copy busy about 2 ms, flag set, eeprom writes ignored meanwhile
// - recall B8h reloads shadow block from eeprom
// - lock 6Ah protects block only when lock enable is set
// - lock enable clears after a lock is executed
// - address holds family code low, 48-bit serial, crc on top
// - write slots sampled between 15 and 60 us after the fall

`define SWS_CLK_NS        5
`define SWS_T_RSTLOW_NS   120000
`define SWS_T_SAMPLE_NS   30000
`define SWS_T_PDH_NS      30000
`define SWS_T_PDL_NS      100000
`define SWS_T_RDRV_NS     30000
`define SWS_T_COPY_NS     2000000
`define SWS_RSTLOW_CYC    ((`SWS_T_RSTLOW_NS + `SWS_CLK_NS - 1) / `SWS_CLK_NS)
`define SWS_SAMPLE_CYC    (`SWS_T_SAMPLE_NS / `SWS_CLK_NS)
`define SWS_PDH_CYC       ((`SWS_T_PDH_NS + `SWS_CLK_NS - 1) / `SWS_CLK_NS)
`define SWS_PDL_CYC       (`SWS_T_PDL_NS / `SWS_CLK_NS)
`define SWS_RDRV_CYC      (`SWS_T_RDRV_NS / `SWS_CLK_NS)
`define SWS_COPY_CYC      (`SWS_T_COPY_NS / `SWS_CLK_NS)

`define SWS_OP_READ_A     8'h33
`define SWS_OP_READ_B     8'h39
`define SWS_OP_MATCH      8'h55
`define SWS_OP_SKIP       8'hCC
`define SWS_OP_SEARCH     8'hF0
`define SWS_OP_SWAP       8'hAA
`define SWS_OP_RDATA      8'h69
`define SWS_OP_WDATA      8'h6C
`define SWS_OP_COPY       8'h48
`define SWS_OP_RECALL     8'hB8
`define SWS_OP_LOCK       8'h6A

`define SWS_CRC_POLY      8'h8C
`define SWS_ADDR_LAST     6'h3F
`define SWS_BYTE_LAST     3'h7
`define SWS_MEM_TOP       8'hFF
`define SWS_A_STATUS      8'h01
`define SWS_A_EEREG       8'h07
`define SWS_A_EE_LO       8'h20
`define SWS_A_EE_HI       8'h3F
`define SWS_A_SRAM_LO     8'h80
`define SWS_A_SRAM_HI     8'h8F
`define SWS_B_NET_ADDRESS_READ_OPCODE_SELECT       4
`define SWS_B_SWAP_ENABLE        3
`define SWS_B_EEC         7
`define SWS_B_LOCK        6
`define SWS_B_BL1         1
`define SWS_B_BL0         0
`define SWS_B_BLK         4
`define SWS_EE_BLANK      8'hFF
`define SWS_ZERO8         8'h00
`endif

// ---- rtl/sws_pkg.sv ----
package sws_pkg;
  typedef enum logic [3:0]
  {
    SWS_IDLE,
    SWS_RST_LOW,
    SWS_PRES_WAIT,
    SWS_PRES_DRIVE,
    SWS_ROM_CMD,
    SWS_READ_ROM,
    SWS_MATCH,
    SWS_SEARCH,
    SWS_SWAP_ADDR,
    SWS_SWAP_PULSE,
    SWS_FUNC_CMD,
    SWS_FUNC_ADDR,
    SWS_READ_DATA,
    SWS_WRITE_DATA,
    SWS_DONE
  } sws_state_e;
endpackage

// ---- rtl/sws_crc8.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sws_defines.svh"
module sws_crc8
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       shift,
  input  wire logic       din,
  output logic [7:0]      crc
);
  logic fb;

  assign fb = din ^ crc[0];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      crc <= `SWS_ZERO8;
    else if (shift)
      crc <= (crc >> 1) ^ (fb ? `SWS_CRC_POLY : `SWS_ZERO8);
  end
endmodule
`default_nettype wire

// ---- rtl/sws_line_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module sws_line_timer
#(
  parameter int unsigned RST_CYC    = 24000,
  parameter int unsigned SAMPLE_CYC = 6000
)
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic dq_in,
  output logic      fall_pulse,
  output logic      rise_pulse,
  output logic      sample_pulse,
  output logic      sample_bit,
  output logic      reset_pulse
);
  localparam int unsigned W = $clog2(RST_CYC + 1);

  initial
  begin
    if (SAMPLE_CYC < 1 || SAMPLE_CYC >= RST_CYC)
      $error("sws_line_timer: sample point must lie inside reset time");
  end

  logic         dq_prev_reg;
  logic [W-1:0] low_cnt_reg;
  logic [W-1:0] slot_cnt_reg;
  logic         slot_run_reg;

  assign fall_pulse   = dq_prev_reg & ~dq_in;
  assign rise_pulse   = ~dq_prev_reg & dq_in;
  assign sample_pulse = slot_run_reg && (slot_cnt_reg == W'(SAMPLE_CYC));
  assign sample_bit   = dq_in;
  // saturating counter gives one pulse per long low
  assign reset_pulse  = !dq_in && (low_cnt_reg == W'(RST_CYC - 1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      dq_prev_reg <= 1'b1;
    else
      dq_prev_reg <= dq_in;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_reg <= '0;
    else if (dq_in)
      low_cnt_reg <= '0;
    else if (low_cnt_reg != W'(RST_CYC))
      low_cnt_reg <= low_cnt_reg + 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      slot_cnt_reg <= '0;
      slot_run_reg <= 1'b0;
    end
    else if (fall_pulse)
    begin
      slot_cnt_reg <= W'(1);
      slot_run_reg <= 1'b1;
    end
    else if (slot_run_reg)
    begin
      if (sample_pulse)
        slot_run_reg <= 1'b0;
      else
        slot_cnt_reg <= slot_cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sws_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sws_defines.svh"
module sws_slave
#(
  // arbitrary identity values, not any real part's
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,
  parameter logic [47:0] SERIAL_NUM  = 48'h0123456789AB,
  parameter int unsigned RSTLOW_CYC  = `SWS_RSTLOW_CYC,
  parameter int unsigned SAMPLE_CYC  = `SWS_SAMPLE_CYC,
  parameter int unsigned PDH_CYC     = `SWS_PDH_CYC,
  parameter int unsigned PDL_CYC     = `SWS_PDL_CYC,
  parameter int unsigned RDRV_CYC    = `SWS_RDRV_CYC,
  parameter int unsigned COPY_CYC    = `SWS_COPY_CYC
)
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic dq_in,
  output logic      dq_out,
  output logic      dq_oe,
  input  wire logic net_address_read_opcode_select,
  input  wire logic swap_enable,
  output logic      charge_control_output,
  output logic      discharge_control_output,
  output logic      sleep_req,
  output logic      swap_master,
  output logic      eeprom_copy_in_progress,
  output logic      lock_enable_flag,
  output logic      block0_locked_flag,
  output logic      block1_locked_flag
);
  localparam int unsigned TW = $clog2(PDL_CYC + PDH_CYC + RDRV_CYC + 1);
  localparam int unsigned CW = $clog2(COPY_CYC + 1);

  initial
  begin
    if (PDL_CYC >= RSTLOW_CYC || RDRV_CYC < 1 || COPY_CYC < 2)
      $error("sws_slave: timing parameters out of range");
  end

  sws_pkg::sws_state_e state_reg;
  logic [5:0]  bit_cnt_reg;
  logic [63:0] sh_reg;
  logic [1:0]  phase_reg;
  logic        match_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  mem_addr_reg;
  logic        past_end_reg;
  logic [7:0]  tx_byte_reg;
  logic [TW-1:0] tcnt_reg;
  logic [TW-1:0] drv_cnt_reg;
  logic [CW-1:0] copy_cnt_reg;
  logic        copy_blk_reg;
  logic [5:0]  init_cnt_reg;
  logic        init_done_reg;
  logic [1:0]  locked_reg;
  logic [7:0]  shadow_mem [0:31];
  logic [7:0]  eeprom_mem [0:31];
  logic [7:0]  sram_mem   [0:15];

  logic        fall_pulse, rise_pulse, sample_pulse, sample_bit, reset_pulse;
  logic [7:0]  crc;
  logic [55:0] id_bits;
  logic [63:0] net_addr;
  logic [7:0]  rx_byte;
  logic [63:0] rx_addr;
  logic        byte_done;
  logic        tx_active;
  logic        tx_bit;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        exec_fire;
  logic        wr_fire;
  logic        rx_is_ee;
  logic        wr_is_ee;

  sws_line_timer #(.RST_CYC(RSTLOW_CYC), .SAMPLE_CYC(SAMPLE_CYC)) u_timer
  (
    .mclk         (mclk),
    .nrst         (nrst),
    .dq_in        (dq_in),
    .fall_pulse   (fall_pulse),
    .rise_pulse   (rise_pulse),
    .sample_pulse (sample_pulse),
    .sample_bit   (sample_bit),
    .reset_pulse  (reset_pulse)
  );

  assign id_bits  = {SERIAL_NUM, FAMILY_CODE};
  assign net_addr = {crc, id_bits};

  sws_crc8 u_crc
  (
    .mclk  (mclk),
    .nrst  (nrst),
    .shift (!init_done_reg),
    .din   (id_bits[init_cnt_reg]),
    .crc   (crc)
  );

  // crc built once after reset, 56 clocks, long before any slot ends
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_cnt_reg  <= '0;
      init_done_reg <= 1'b0;
    end
    else if (!init_done_reg)
    begin
      if (init_cnt_reg == 6'(55))
        init_done_reg <= 1'b1;
      else
        init_cnt_reg <= init_cnt_reg + 1'b1;
    end
  end

  assign rx_byte   = {sample_bit, sh_reg[63:57]};
  assign rx_addr   = {sample_bit, sh_reg[63:1]};
  assign byte_done = sample_pulse && (bit_cnt_reg[2:0] == `SWS_BYTE_LAST);
  assign rx_is_ee  = (rx_byte >= `SWS_A_EE_LO) && (rx_byte <= `SWS_A_EE_HI);
  assign wr_is_ee  = (mem_addr_reg >= `SWS_A_EE_LO)
                     && (mem_addr_reg <= `SWS_A_EE_HI);
  assign exec_fire = (state_reg == sws_pkg::SWS_FUNC_ADDR) && byte_done;
  assign wr_fire   = (state_reg == sws_pkg::SWS_WRITE_DATA) && byte_done
                     && !past_end_reg;
  assign rd_addr   = (state_reg == sws_pkg::SWS_FUNC_ADDR) ? rx_byte
                     : mem_addr_reg + 1'b1;

  always_comb
  begin
    tx_active = 1'b1;
    tx_bit    = 1'b1;
    case (state_reg)
      sws_pkg::SWS_READ_ROM:  tx_bit = net_addr[bit_cnt_reg];
      sws_pkg::SWS_SEARCH:
      begin
        tx_active = (phase_reg != 2'd2);
        tx_bit    = net_addr[bit_cnt_reg] ^ phase_reg[0];
      end
      sws_pkg::SWS_READ_DATA:
        tx_bit = past_end_reg | tx_byte_reg[bit_cnt_reg[2:0]];
      default: tx_active = 1'b0;
    endcase
  end

  always_comb
  begin
    rd_data = `SWS_ZERO8;
    if (rd_addr == `SWS_A_STATUS)
    begin
      rd_data[`SWS_B_NET_ADDRESS_READ_OPCODE_SELECT] = net_address_read_opcode_select;
      rd_data[`SWS_B_SWAP_ENABLE]  = swap_enable;
    end
    else if (rd_addr == `SWS_A_EEREG)
    begin
      rd_data[`SWS_B_EEC]  = eeprom_copy_in_progress;
      rd_data[`SWS_B_LOCK] = lock_enable_flag;
      rd_data[`SWS_B_BL1]  = locked_reg[1];
      rd_data[`SWS_B_BL0]  = locked_reg[0];
    end
    else if (rd_addr >= `SWS_A_EE_LO && rd_addr <= `SWS_A_EE_HI)
      rd_data = shadow_mem[rd_addr[4:0]];
    else if (rd_addr >= `SWS_A_SRAM_LO && rd_addr <= `SWS_A_SRAM_HI)
      rd_data = sram_mem[rd_addr[3:0]];
  end

  // transaction sequencer; a reset pulse wins over everything
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= sws_pkg::SWS_IDLE;
      bit_cnt_reg  <= '0;
      sh_reg       <= '0;
      phase_reg    <= '0;
      match_reg    <= 1'b0;
      cmd_reg      <= `SWS_ZERO8;
      mem_addr_reg <= `SWS_ZERO8;
      past_end_reg <= 1'b0;
      tx_byte_reg  <= `SWS_ZERO8;
      tcnt_reg     <= '0;
    end
    else if (reset_pulse)
    begin
      state_reg <= sws_pkg::SWS_RST_LOW;
      past_end_reg <= 1'b0;
    end
    else
    begin
      if (sample_pulse)
      begin
        sh_reg      <= rx_addr;
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      case (state_reg)
        sws_pkg::SWS_RST_LOW:
          if (rise_pulse)
          begin
            state_reg <= sws_pkg::SWS_PRES_WAIT;
            tcnt_reg  <= TW'(PDH_CYC);
          end
        sws_pkg::SWS_PRES_WAIT:
          if (tcnt_reg == TW'(1))
          begin
            state_reg <= sws_pkg::SWS_PRES_DRIVE;
            tcnt_reg  <= TW'(PDL_CYC);
          end
          else
            tcnt_reg <= tcnt_reg - 1'b1;
        sws_pkg::SWS_PRES_DRIVE:
          if (tcnt_reg == TW'(1))
          begin
            state_reg   <= sws_pkg::SWS_ROM_CMD;
            bit_cnt_reg <= '0;
          end
          else
            tcnt_reg <= tcnt_reg - 1'b1;
        sws_pkg::SWS_ROM_CMD:
          if (byte_done)
          begin
            bit_cnt_reg <= '0;
            phase_reg   <= '0;
            if (rx_byte == (net_address_read_opcode_select
                            ? `SWS_OP_READ_B : `SWS_OP_READ_A))
              state_reg <= sws_pkg::SWS_READ_ROM;
            else if (rx_byte == `SWS_OP_MATCH)
              state_reg <= sws_pkg::SWS_MATCH;
            else if (rx_byte == `SWS_OP_SKIP)
              state_reg <= sws_pkg::SWS_FUNC_CMD;
            else if (rx_byte == `SWS_OP_SEARCH)
              state_reg <= sws_pkg::SWS_SEARCH;
            else if (rx_byte == `SWS_OP_SWAP && swap_enable)
              state_reg <= sws_pkg::SWS_SWAP_ADDR;
            else
              state_reg <= sws_pkg::SWS_DONE;
          end
        sws_pkg::SWS_READ_ROM:
          if (sample_pulse && bit_cnt_reg == `SWS_ADDR_LAST)
          begin
            state_reg   <= sws_pkg::SWS_FUNC_CMD;
            bit_cnt_reg <= '0;
          end
        sws_pkg::SWS_MATCH, sws_pkg::SWS_SWAP_ADDR:
          if (sample_pulse && bit_cnt_reg == `SWS_ADDR_LAST)
          begin
            bit_cnt_reg <= '0;
            match_reg   <= (rx_addr == net_addr);
            phase_reg   <= '0;
            if (state_reg == sws_pkg::SWS_SWAP_ADDR)
              state_reg <= sws_pkg::SWS_SWAP_PULSE;
            else if (rx_addr == net_addr)
              state_reg <= sws_pkg::SWS_FUNC_CMD;
            else
              state_reg <= sws_pkg::SWS_DONE;
          end
        sws_pkg::SWS_SEARCH:
          if (sample_pulse)
          begin
            bit_cnt_reg <= bit_cnt_reg;
            if (phase_reg != 2'd2)
              phase_reg <= phase_reg + 1'b1;
            else if (sample_bit != net_addr[bit_cnt_reg])
              state_reg <= sws_pkg::SWS_DONE;
            else if (bit_cnt_reg == `SWS_ADDR_LAST)
            begin
              state_reg   <= sws_pkg::SWS_FUNC_CMD;
              bit_cnt_reg <= '0;
            end
            else
            begin
              phase_reg   <= '0;
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
        sws_pkg::SWS_SWAP_PULSE:
          if (fall_pulse)
            phase_reg <= 2'd1;
          else if (rise_pulse && phase_reg[0])
            state_reg <= sws_pkg::SWS_DONE;
        sws_pkg::SWS_FUNC_CMD:
          if (byte_done)
          begin
            bit_cnt_reg <= '0;
            cmd_reg     <= rx_byte;
            if (rx_byte == `SWS_OP_RDATA || rx_byte == `SWS_OP_WDATA
                || rx_byte == `SWS_OP_COPY || rx_byte == `SWS_OP_RECALL
                || rx_byte == `SWS_OP_LOCK)
              state_reg <= sws_pkg::SWS_FUNC_ADDR;
            else
              state_reg <= sws_pkg::SWS_DONE;
          end
        sws_pkg::SWS_FUNC_ADDR:
          if (byte_done)
          begin
            bit_cnt_reg  <= '0;
            mem_addr_reg <= rx_byte;
            tx_byte_reg  <= rd_data;
            if (cmd_reg == `SWS_OP_RDATA)
              state_reg <= sws_pkg::SWS_READ_DATA;
            else if (cmd_reg == `SWS_OP_WDATA)
              state_reg <= sws_pkg::SWS_WRITE_DATA;
            else
              state_reg <= sws_pkg::SWS_DONE;
          end
        sws_pkg::SWS_READ_DATA, sws_pkg::SWS_WRITE_DATA:
          if (byte_done)
          begin
            bit_cnt_reg <= '0;
            tx_byte_reg <= rd_data;
            if (mem_addr_reg == `SWS_MEM_TOP)
              past_end_reg <= 1'b1;
            else
              mem_addr_reg <= mem_addr_reg + 1'b1;
          end
        default: ;
      endcase
    end
  end

  // open-drain: only the enable moves, the data level stays low
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_oe       <= 1'b0;
      dq_out      <= 1'b0;
      drv_cnt_reg <= '0;
    end
    else if (reset_pulse)
    begin
      dq_oe       <= 1'b0;
      drv_cnt_reg <= '0;
    end
    else if (state_reg == sws_pkg::SWS_PRES_DRIVE)
      dq_oe <= 1'b1;
    else if (fall_pulse && tx_active && !tx_bit)
    begin
      dq_oe       <= 1'b1;
      drv_cnt_reg <= TW'(RDRV_CYC);
    end
    else if (drv_cnt_reg > TW'(1))
      drv_cnt_reg <= drv_cnt_reg - 1'b1;
    else
    begin
      drv_cnt_reg <= '0;
      dq_oe       <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      charge_control_output    <= 1'b1;
      discharge_control_output <= 1'b1;
      sleep_req                <= 1'b0;
      swap_master              <= 1'b0;
    end
    else if (reset_pulse)
      sleep_req <= 1'b0;
    else if (state_reg == sws_pkg::SWS_SWAP_PULSE)
    begin
      if (fall_pulse)
      begin
        charge_control_output    <= 1'b0;
        discharge_control_output <= 1'b0;
      end
      else if (rise_pulse && phase_reg[0])
      begin
        charge_control_output    <= match_reg;
        discharge_control_output <= match_reg;
        swap_master              <= match_reg;
        sleep_req                <= !match_reg;
      end
    end
  end

  // shadow and scratch writes; crc mismatches never block them
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 32; i++)
        shadow_mem[i] <= `SWS_EE_BLANK;
      for (int i = 0; i < 16; i++)
        sram_mem[i] <= `SWS_ZERO8;
    end
    else if (wr_fire)
    begin
      if (wr_is_ee && !eeprom_copy_in_progress
          && !locked_reg[mem_addr_reg[`SWS_B_BLK]])
        shadow_mem[mem_addr_reg[4:0]] <= rx_byte;
      else if (mem_addr_reg >= `SWS_A_SRAM_LO
               && mem_addr_reg <= `SWS_A_SRAM_HI)
        sram_mem[mem_addr_reg[3:0]] <= rx_byte;
    end
    else if (exec_fire && cmd_reg == `SWS_OP_RECALL && rx_is_ee)
    begin
      for (int i = 0; i < 16; i++)
        shadow_mem[{rx_byte[`SWS_B_BLK], 4'(i)}]
          <= eeprom_mem[{rx_byte[`SWS_B_BLK], 4'(i)}];
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      copy_cnt_reg            <= '0;
      copy_blk_reg            <= 1'b0;
      eeprom_copy_in_progress <= 1'b0;
      for (int i = 0; i < 32; i++)
        eeprom_mem[i] <= `SWS_EE_BLANK;
    end
    else if (exec_fire && cmd_reg == `SWS_OP_COPY && rx_is_ee
             && !locked_reg[rx_byte[`SWS_B_BLK]]
             && !eeprom_copy_in_progress)
    begin
      copy_cnt_reg            <= CW'(COPY_CYC);
      copy_blk_reg            <= rx_byte[`SWS_B_BLK];
      eeprom_copy_in_progress <= 1'b1;
    end
    else if (copy_cnt_reg == CW'(1))
    begin
      copy_cnt_reg            <= '0;
      eeprom_copy_in_progress <= 1'b0;
      for (int i = 0; i < 16; i++)
        eeprom_mem[{copy_blk_reg, 4'(i)}]
          <= shadow_mem[{copy_blk_reg, 4'(i)}];
    end
    else if (copy_cnt_reg != '0)
      copy_cnt_reg <= copy_cnt_reg - 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lock_enable_flag <= 1'b0;
      locked_reg       <= '0;
    end
    else if (exec_fire && cmd_reg == `SWS_OP_LOCK && rx_is_ee)
    begin
      if (lock_enable_flag)
      begin
        locked_reg[rx_byte[`SWS_B_BLK]] <= 1'b1;
        lock_enable_flag                <= 1'b0;
      end
    end
    else if (wr_fire && mem_addr_reg == `SWS_A_EEREG)
      lock_enable_flag <= rx_byte[`SWS_B_LOCK];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      block0_locked_flag <= 1'b0;
      block1_locked_flag <= 1'b0;
    end
    else
    begin
      block0_locked_flag <= locked_reg[0];
      block1_locked_flag <= locked_reg[1];
    end
  end
endmodule
`default_nettype wire

// ---- bench/sws_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sws_properties
#(
  parameter int RSTLOW_CYC = 200,
  parameter int PDH_CYC    = 20,
  parameter int PDL_CYC    = 100,
  parameter int RDRV_CYC   = 40,
  parameter int COPY_CYC   = 50
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire logic net_address_read_opcode_select,
  input wire logic swap_enable,
  input wire logic charge_control_output,
  input wire logic discharge_control_output,
  input wire logic sleep_req,
  input wire logic swap_master,
  input wire logic eeprom_copy_in_progress,
  input wire logic lock_enable_flag,
  input wire logic block0_locked_flag,
  input wire logic block1_locked_flag
);
  // slack of a few cycles for edge detection and output registers
  localparam int PD_LO = PDH_CYC - 2;
  localparam int PD_HI = PDH_CYC + 3;
  int low_cnt;
  int oe_cnt;
  int cp_cnt;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      low_cnt <= 0;
    else
      low_cnt <= dq_in ? 0 : low_cnt + 1;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      oe_cnt <= 0;
    else
      oe_cnt <= dq_oe ? oe_cnt + 1 : 0;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      cp_cnt <= 0;
    else
      cp_cnt <= eeprom_copy_in_progress ? cp_cnt + 1 : 0;
  AST_DQ_OUT_LOW: assert property (dq_out == 1'b0)
    else $error("data output driven high");
  AST_PRESENCE: assert property (
    $rose(dq_in) && low_cnt >= RSTLOW_CYC |-> ##[PD_LO:PD_HI] dq_oe)
    else $error("no presence after bus reset");
  AST_RESET_QUIET: assert property (
    low_cnt == RSTLOW_CYC + 2 |-> !dq_oe)
    else $error("line driven during bus reset");
  AST_DRIVE_LEN: assert property (
    $fell(dq_oe) |-> oe_cnt == RDRV_CYC || oe_cnt == PDL_CYC)
    else $error("line drive length wrong");
  AST_COPY_LEN: assert property (
    $fell(eeprom_copy_in_progress)
      |-> cp_cnt >= COPY_CYC - 1 && cp_cnt <= COPY_CYC + 1)
    else $error("copy busy length wrong");
  AST_SWAP_FALL: assert property (
    $fell(charge_control_output)
      |-> swap_enable && !discharge_control_output)
    else $error("power cut without enabled swap");
  AST_SWAP_RISE: assert property (
    $rose(swap_master) |-> charge_control_output && !sleep_req)
    else $error("swap master without power");
  AST_LOCK_CLEAR: assert property (
    $rose(block0_locked_flag) || $rose(block1_locked_flag)
      |-> !lock_enable_flag)
    else $error("lock enable not cleared");
  AST_LOCK_EN: assert property (
    $rose(block0_locked_flag)
      |-> $past(lock_enable_flag, 2) || $past(lock_enable_flag, 3))
    else $error("block locked without enable");
  cover property ($rose(swap_master));
  cover property ($rose(block0_locked_flag));
  cover property ($fell(eeprom_copy_in_progress));
endmodule
`default_nettype wire

// ---- bench/sws_bus_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module sws_bus_master
(
  input  wire logic mclk,
  input  wire logic dev_oe,
  output logic      dq
);
  logic pull_low = 1'b0;
  // pull-up resistor: line high unless some party pulls it low
  assign dq = ~(pull_low | dev_oe);
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // line always left released high between operations
  task automatic bus_reset(output logic pres);
    pull_low = 1'b1;
    hold(250);
    pull_low = 1'b0;
    hold(60);
    pres = ~dq;
    hold(100);
  endtask
  // zero held past the device sampling window
  task automatic slot(input logic wb, output logic rb);
    pull_low = 1'b1;
    hold(wb ? 2 : 60);
    pull_low = 1'b0;
    hold(wb ? 13 : 1);
    rb = dq;
    hold(wb ? 65 : 19);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 0; i < 8; i++)
      slot(b[i], r);
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // arbitrary identity values
  localparam logic [7:0]  FAM = 8'h5A;
  localparam logic [47:0] SER = 48'h0123456789AB;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic net_address_read_opcode_select = 1'b0;
  logic swap_enable = 1'b0;
  logic dq_in, dq_out, dq_oe, sleep_req, swap_master;
  logic charge_control_output, discharge_control_output;
  logic eeprom_copy_in_progress, lock_enable_flag;
  logic block0_locked_flag, block1_locked_flag;
  logic [63:0] own, got;
  logic [7:0]  d0, d1, v;
  logic        p, r1, r2;
  int          fails = 0;
  int          tests_run = 0;
  // identity and copy length stay at their defaults; copy outlasts the run
  sws_slave #(.RSTLOW_CYC(200), .SAMPLE_CYC(40), .PDH_CYC(20),
    .PDL_CYC(100), .RDRV_CYC(40)) dut (.*);
  sws_bus_master m (.mclk(mclk), .dev_oe(dq_oe), .dq(dq_in));
  initial
    forever #2.5 mclk = ~mclk;
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c >> 1) ^ ((d[i] ^ c[0]) ? 8'h8C : 8'h00);
    return c;
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rbyte(output logic [7:0] x);
    for (int i = 0; i < 8; i++)
      m.slot(1'b1, x[i]);
  endtask
  task automatic start(input logic [7:0] rom);
    m.bus_reset(p);
    chk(64'(p), 64'h1);
    m.wbyte(rom);
  endtask
  task automatic fcmd(input logic [7:0] rom, input logic [63:0] ad,
                      input logic [7:0] fn, input logic [7:0] a);
    start(rom);
    if (rom == 8'h55 || rom == 8'hAA)
      for (int i = 0; i < 8; i++)
        m.wbyte(ad[8*i+:8]);
    if (rom != 8'hAA)
    begin
      m.wbyte(fn);
      m.wbyte(a);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    own = {crc8({SER, FAM}), SER, FAM};
    void'($urandom(57));
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    for (int s = 0; s < 2; s++)
    begin
      net_address_read_opcode_select = s[0];
      start(s[0] ? 8'h39 : 8'h33);
      for (int i = 0; i < 8; i++)
        rbyte(got[8*i+:8]);
      chk(got, own);
    end
    start(8'hF0);
    for (int i = 0; i < 64; i++)
    begin
      m.slot(1'b1, r1);
      m.slot(1'b1, r2);
      chk(64'({r1, r2}), 64'({own[i], ~own[i]}));
      m.slot(own[i], r1);
    end
    fcmd(8'hCC, own, 8'h6C, 8'h8F);
    m.wbyte(d0);
    m.wbyte(d1);
    fcmd(8'h55, own, 8'h69, 8'h8F);
    rbyte(v);
    chk(64'(v), 64'(d0));
    rbyte(v);
    chk(64'(v), 64'h0);
    fcmd(8'hCC, own, 8'h69, 8'hFF);
    rbyte(v);
    chk(64'(v), 64'h0);
    rbyte(v);
    chk(64'(v), 64'hFF);
    fcmd(8'h55, own ^ 64'h1, 8'h69, 8'h8F);
    rbyte(v);
    chk(64'(v), 64'hFF);
    fcmd(8'hCC, own, 8'h6A, 8'h25);
    chk(64'(block0_locked_flag), 64'h0);
    fcmd(8'hCC, own, 8'h6C, 8'h07);
    m.wbyte(8'h40);
    chk(64'(lock_enable_flag), 64'h1);
    fcmd(8'hCC, own, 8'h6A, 8'h25);
    chk(64'({block0_locked_flag, lock_enable_flag}), 64'h2);
    fcmd(8'hCC, own, 8'h6C, 8'h2F);
    m.wbyte(d1);
    fcmd(8'hCC, own, 8'h69, 8'h2F);
    rbyte(v);
    chk(64'(v), 64'hFF);
    fcmd(8'hCC, own, 8'h6C, 8'h30);
    m.wbyte(d0);
    fcmd(8'hCC, own, 8'h48, 8'h30);
    chk(64'(eeprom_copy_in_progress), 64'h1);
    fcmd(8'hCC, own, 8'h6C, 8'h30);
    m.wbyte(d1);
    fcmd(8'hCC, own, 8'h69, 8'h30);
    rbyte(v);
    chk(64'(v), 64'(d0));
    // eeprom still blank, so recall brings back FF
    fcmd(8'hCC, own, 8'hB8, 8'h3A);
    fcmd(8'hCC, own, 8'h69, 8'h30);
    rbyte(v);
    chk(64'(v), 64'hFF);
    swap_enable = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      fcmd(8'hAA, own ^ 64'(k), 8'h00, 8'h00);
      m.pull_low = 1'b1;
      m.hold(20);
      v = 8'({charge_control_output, discharge_control_output});
      chk(64'(v), 64'h0);
      m.pull_low = 1'b0;
      m.hold(20);
      v = 8'({charge_control_output, swap_master, sleep_req});
      chk(64'(v), k ? 64'h1 : 64'h6);
    end
    tally_and_finish();
  end
  initial
  begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule
bind sws_slave sws_properties #(.RSTLOW_CYC(RSTLOW_CYC), .PDH_CYC(PDH_CYC),
  .PDL_CYC(PDL_CYC), .RDRV_CYC(RDRV_CYC), .COPY_CYC(COPY_CYC)) u_props (.*);
`default_nettype wire
